// [src/urc_pkg.sv]
package urc_pkg;
  localparam int         CLK_HZ    = 200_000_000;
  localparam int         AW        = 6;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IX_MODE   = 4'h0;
  localparam logic [3:0] IX_STAT   = 4'h1;
  localparam logic [3:0] IX_RATE   = 4'h2;
  localparam logic [3:0] IX_DATA   = 4'h3;
  localparam logic [3:0] IX_CMD    = 4'h4;
  localparam logic [3:0] IX_CSEL   = 4'h5;
  localparam logic [3:0] IX_AUX    = 4'h6;
  localparam logic [3:0] IX_ISTAT  = 4'h7;
  localparam logic [3:0] IX_IMASK  = 4'h8;
  localparam logic [3:0] IX_TEST   = 4'ha;
  localparam int         WAKE_LO   = 3;
  localparam int         CSEL_LO   = 4;
  localparam int         AUX_BIT   = 7;
  localparam logic [1:0] WAKE_CODE = 2'b11;
  localparam logic [3:0] CS_TIMER  = 4'hd;
  localparam logic [3:0] CS_EXT16  = 4'he;
  localparam logic [3:0] CS_EXT1   = 4'hf;
  localparam int         C_TXEN    = 0;
  localparam int         C_TXDIS   = 1;
  localparam int         C_RXEN    = 2;
  localparam int         C_RXDIS   = 3;
  localparam int         C_RXRST   = 4;
  localparam int         NIRQ      = 3;
  localparam logic [3:0] SUB_LAST  = 4'hf;
  localparam logic [3:0] SUB_MID   = 4'h7;
  localparam logic [3:0] ARM_TICKS = 4'h3;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
                            TX_STOP = 3'b010} urc_tx_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11,
                            RX_STOP = 2'b10} urc_rx_t;

  // Rates in tenths of a baud, turned into 16x divisors
  function automatic logic [19:0] urc_div(input int r10);
    return 20'(64'(CLK_HZ) * 64'd10 / (64'd16 * 64'(r10)));
  endfunction : urc_div

  function automatic logic [19:0] urc_rate_div(input logic [3:0] cs, input logic aux, input logic ext);
    int r;
    r = 96000;
    case (cs)
      4'h0:    r = ext ? (aux ? 72000 : 48000) : (aux ? 750 : 500);
      4'h1:    r = ext ? 8800 : 1100;
      4'h2:    r = ext ? 10760 : 1345;
      4'h3:    r = ext ? (aux ? 144000 : 192000) : (aux ? 1500 : 2000);
      4'h4:    r = ext ? 288000 : 3000;
      4'h5:    r = ext ? 576000 : 6000;
      4'h6:    r = ext ? 1152000 : 12000;
      4'h7:    r = aux ? 20000 : 10500;
      4'h8:    r = ext ? 576000 : 24000;
      4'h9:    r = 48000;
      4'ha:    r = ext ? (aux ? 144000 : 576000) : (aux ? 18000 : 72000);
      4'hc:    r = aux ? 192000 : 384000;
      default: r = 96000;
    endcase
    return urc_div(r);
  endfunction : urc_rate_div
endpackage : urc_pkg

// [src/urc_top.sv]
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
//
// Contract
// - Disable within 3/16 bit (16x) or one bit (1x) of load sends nothing.
// - Disable right after loading during underrun discards that character.
// - Transmitter-empty flag set on underrun and just after enabling.
// - Holding-ready flag rises at the end of the start bit.
// - Holding register moves into the shift register during the start bit.
// - Clock-select code plus rate-set bit picks a rate from two tables.
// - Codes 1101, 1110, 1111 select timer, external 16x, external 1x.
// - Extended mode substitutes the alternative rates for affected codes.
// - Each read of index 0x2 toggles normal and extended rate tables.
// - Rate mode toggle affects every receiver and transmitter together.
// - Test index 0xA forces 1x clocking and shows internal nodes on pins.
// - Receiver reset then enable leaves all mode programming untouched.
// - In wake-up mode receiver disable and reset commands have no effect.
//
module urc_top
  import urc_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [urc_pkg::AW-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      irq,
  output logic                      txd,
  input  wire logic                 rxd_pin,
  input  wire logic                 external_clock_pin,
  input  wire logic                 timer_tick,
  output logic      [7:0]           test_port
);
  import urc_pkg::*;

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  logic [3:0]  idx;
  logic        mapped, acc, wr, rd;
  logic [31:0] rdata_d, prdata_q;
  logic [7:0]  mode_q;
  logic [3:0]  clock_select_field;
  logic        aux_rate_set_bit, ext_q, test_q;
  logic [NIRQ-1:0] istat_q, imask_q, ev;
  logic [7:0]  thr_q, tx_sh_q, rx_sh_q, rx_data_q;
  logic        thr_full_q, tx_en_q, tx_empty_flag, tx_holding_ready_flag;
  logic        rx_en_q, rx_ready_q;

  assign idx     = paddr[5:2];
  assign mapped  = (idx <= IX_IMASK) || (idx == IX_TEST);
  assign acc     = psel & penable;
  assign wr      = acc & pwrite & mapped;
  assign rd      = acc & ~pwrite & mapped;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = prdata_q;

  always_comb begin
    rdata_d = 32'h0;
    case (idx)
      IX_MODE:  rdata_d[7:0] = mode_q;
      IX_STAT:  rdata_d[6:0] = {tx_en_q, test_q, ext_q, tx_empty_flag, tx_holding_ready_flag, rx_en_q, rx_ready_q};
      IX_RATE:  rdata_d[0] = ext_q;
      IX_DATA:  rdata_d[7:0] = rx_data_q;
      IX_CSEL:  rdata_d[CSEL_LO+:4] = clock_select_field;
      IX_AUX:   rdata_d[AUX_BIT] = aux_rate_set_bit;
      IX_ISTAT: rdata_d[NIRQ-1:0] = istat_q;
      IX_IMASK: rdata_d[NIRQ-1:0] = imask_q;
      IX_TEST:  rdata_d[0] = test_q;
      default:  rdata_d = 32'h0;
    endcase
  end

  // Read data settles in the setup cycle so the answer has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0;
    else if (psel & ~penable) prdata_q <= rdata_d;
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q             <= 8'h0;
      clock_select_field <= 4'h0;
      aux_rate_set_bit   <= 1'b0;
      imask_q            <= '0;
      test_q             <= 1'b0;
    end else if (wr) begin
      // Receiver commands never reach these, so a reset keeps the programming
      if (idx == IX_MODE) mode_q <= pwdata[7:0];
      if (idx == IX_CSEL) clock_select_field <= pwdata[CSEL_LO+:4];
      if (idx == IX_AUX) aux_rate_set_bit <= pwdata[AUX_BIT];
      if (idx == IX_IMASK) imask_q <= pwdata[NIRQ-1:0];
      if (idx == IX_TEST) test_q <= pwdata[0];
    end
  end

  // One shared mode flag feeds every rate lookup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_q <= 1'b0;
    else if (rd && idx == IX_RATE) ext_q <= ~ext_q;
  end

  // ------------------------------------------------------------
  // Rate generator and clock source
  // ------------------------------------------------------------
  logic [19:0] div, brg_q;
  logic        brg_tick_q, src_tick, one_x;
  logic [2:0]  ext_s_q;
  logic        ext_f_q, ext_f_d;

  assign div = urc_rate_div(clock_select_field, aux_rate_set_bit, ext_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_q      <= 20'h0;
      brg_tick_q <= 1'b0;
    end else begin
      brg_tick_q <= (brg_q >= div - 20'h1);
      brg_q      <= (brg_q >= div - 20'h1) ? 20'h0 : brg_q + 20'h1;
    end
  end

  assign ext_f_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_f_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s_q <= 3'h0;
      ext_f_q <= 1'b0;
    end else begin
      ext_s_q <= {ext_s_q[1:0], external_clock_pin};
      ext_f_q <= ext_f_d;
    end
  end

  always_comb begin
    case (clock_select_field)
      CS_TIMER: src_tick = timer_tick;
      CS_EXT16,
      CS_EXT1:  src_tick = ext_f_d & ~ext_f_q;
      default:  src_tick = brg_tick_q;
    endcase
  end

  assign one_x = (clock_select_field == CS_EXT1) | test_q;

  // ------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------
  urc_tx_t    tx_state_q;
  logic [3:0] tx_sub_q;
  logic [2:0] tx_bit_q;
  logic       txd_q, tx_bit_end, tx_early, tx_dis, tx_ena, thr_load, discard, start_end;

  assign tx_dis     = wr && idx == IX_CMD && pwdata[C_TXDIS];
  assign tx_ena     = wr && idx == IX_CMD && pwdata[C_TXEN] && !pwdata[C_TXDIS];
  assign thr_load   = wr && idx == IX_DATA && !thr_full_q;
  assign tx_bit_end = src_tick & (one_x | tx_sub_q == SUB_LAST);
  // Start bit is still revocable within its first 3/16, or all of it at 1x
  assign tx_early   = one_x | (tx_sub_q < ARM_TICKS);
  assign discard    = tx_dis & (tx_state_q == TX_IDLE | (tx_state_q == TX_START & tx_early));
  assign start_end  = tx_state_q == TX_START & tx_bit_end & !discard;
  assign tx_holding_ready_flag = ~thr_full_q;
  assign txd = txd_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_en_q <= 1'b0;
    else if (tx_dis) tx_en_q <= 1'b0;
    else if (tx_ena) tx_en_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q      <= 8'h0;
      thr_full_q <= 1'b0;
    end else if (discard) thr_full_q <= 1'b0;
    else if (start_end) thr_full_q <= 1'b0;
    else if (thr_load) begin
      thr_q      <= pwdata[7:0];
      thr_full_q <= 1'b1;
    end
  end

  // Enable wins over a load so the flag reads set right after enabling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_empty_flag <= 1'b1;
    else if (tx_ena) tx_empty_flag <= 1'b1;
    else if (thr_load) tx_empty_flag <= 1'b0;
    else if (tx_state_q == TX_IDLE && !thr_full_q) tx_empty_flag <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= 8'h0;
      txd_q      <= 1'b1;
    end else begin
      if (src_tick) tx_sub_q <= tx_bit_end ? 4'h0 : tx_sub_q + 4'h1;
      case (tx_state_q)
        TX_IDLE: begin
          txd_q    <= 1'b1;
          tx_sub_q <= 4'h0;
          if (tx_en_q && thr_full_q && !tx_dis && (src_tick || !one_x)) begin
            tx_state_q <= TX_START;
            txd_q      <= 1'b0;
          end
        end
        TX_START: begin
          if (discard) begin
            tx_state_q <= TX_IDLE;
            txd_q      <= 1'b1;
          end else if (tx_bit_end) begin
            tx_sh_q    <= thr_q;
            txd_q      <= thr_q[0];
            tx_bit_q   <= 3'h0;
            tx_state_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_sh_q  <= tx_sh_q >> 1;
            tx_bit_q <= tx_bit_q + 3'h1;
            txd_q    <= (tx_bit_q == LAST_BIT) ? 1'b1 : tx_sh_q[1];
            if (tx_bit_q == LAST_BIT) tx_state_q <= TX_STOP;
          end
        end
        TX_STOP: if (tx_bit_end) tx_state_q <= TX_IDLE;
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  urc_rx_t    rx_state_q;
  logic [3:0] rx_sub_q;
  logic [2:0] rx_bit_q, rx_s_q;
  logic       rx_f_q, wake, rx_ena, rx_dis, rx_rst, rx_on, rx_sample, rx_done, rx_rd;

  assign wake   = mode_q[WAKE_LO+:2] == WAKE_CODE;
  // Partial enable in wake-up mode bypasses disable and reset
  assign rx_dis = wr && idx == IX_CMD && pwdata[C_RXDIS] && !wake;
  assign rx_rst = wr && idx == IX_CMD && pwdata[C_RXRST] && !wake;
  assign rx_ena = wr && idx == IX_CMD && pwdata[C_RXEN];
  assign rx_on  = rx_en_q | wake;
  assign rx_sample = src_tick & (one_x | rx_sub_q == (rx_state_q == RX_START ? SUB_MID : SUB_LAST));
  assign rx_done = rx_state_q == RX_STOP && rx_sample && !rx_rst;
  assign rx_rd  = rd && idx == IX_DATA;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s_q <= 3'h7;
      rx_f_q <= 1'b1;
    end else begin
      rx_s_q <= {rx_s_q[1:0], rxd_pin};
      if (rx_s_q[1] == rx_s_q[2]) rx_f_q <= rx_s_q[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_en_q <= 1'b0;
    else if (rx_dis | rx_rst) rx_en_q <= 1'b0;
    else if (rx_ena) rx_en_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= RX_IDLE;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= 8'h0;
      rx_data_q  <= 8'h0;
    end else if (rx_rst || !rx_on) begin
      rx_state_q <= RX_IDLE;
      rx_sub_q   <= 4'h0;
    end else begin
      if (src_tick) rx_sub_q <= rx_sample ? 4'h0 : rx_sub_q + 4'h1;
      case (rx_state_q)
        RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (!rx_f_q) rx_state_q <= RX_START;
        end
        RX_START: if (rx_sample) begin
          rx_state_q <= rx_f_q ? RX_IDLE : RX_DATA;
          rx_bit_q   <= 3'h0;
        end
        RX_DATA: if (rx_sample) begin
          rx_sh_q  <= {rx_f_q, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == LAST_BIT) rx_state_q <= RX_STOP;
        end
        RX_STOP: if (rx_sample) begin
          rx_data_q  <= rx_sh_q;
          rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // A new character wins over the read that would clear the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_ready_q <= 1'b0;
    else if (rx_done) rx_ready_q <= 1'b1;
    else if (rx_rst | rx_rd) rx_ready_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Interrupts, test port
  // ------------------------------------------------------------
  assign ev = {rx_done, (tx_state_q == TX_IDLE && !thr_full_q && !tx_empty_flag), start_end};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) istat_q <= '0;
    else if (wr && idx == IX_ISTAT) istat_q <= (istat_q & ~pwdata[NIRQ-1:0]) | ev;
    else istat_q <= istat_q | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq <= 1'b0;
    else irq <= |(istat_q & imask_q);
  end

  // Internal nodes only leave the block in test mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) test_port <= 8'h0;
    else test_port <= test_q ? {tx_state_q, rx_state_q, src_tick, one_x, txd_q} : 8'h0;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load_disable;
    (thr_load && tx_state_q == TX_IDLE) ##[1:3] tx_dis;
  endsequence

  early_abort_a: assert property (tx_state_q == TX_START && tx_early && tx_dis |=>
    tx_state_q == TX_IDLE && txd_q && !thr_full_q) else $error("early disable still sends");
  underrun_disc_a: assert property (s_load_disable ##0 tx_state_q != TX_DATA |=>
    !thr_full_q && txd_q) else $error("character sent after quick disable");
  empty_enable_a: assert property (tx_ena |=> tx_empty_flag) else $error("empty flag not set on enable");
  ready_start_a: assert property (start_end |=> tx_holding_ready_flag && tx_state_q == TX_DATA
    && !$past(tx_holding_ready_flag)) else $error("ready not at end of start bit");
  shift_load_a: assert property (start_end |=> tx_sh_q == $past(thr_q) && txd_q == $past(thr_q[0]))
    else $error("holding data not moved into shift register");
  rate_9600_a: assert property (clock_select_field == 4'hb |-> div == urc_div(96000))
    else $error("code 1011 not 9600");
  ext_src_a: assert property (clock_select_field == CS_EXT1 |-> one_x) else $error("1x source not 1x");
  ext_rate_a: assert property (ext_q && clock_select_field == 4'h6 |-> div == urc_div(1152000))
    else $error("extended code 0110 wrong");
  rate_toggle_a: assert property (rd && idx == IX_RATE |=> ext_q != $past(ext_q))
    else $error("rate mode not toggled");
  test_onex_a: assert property (test_q |-> one_x && tx_bit_end == src_tick)
    else $error("test mode not 1x");
  mode_keep_a: assert property (rx_rst |=> $stable(mode_q)) else $error("reset changed mode");
  wake_keep_a: assert property (wake && rx_en_q && acc && pwrite && idx == IX_CMD |=> rx_en_q)
    else $error("wake-up receiver disabled");
  bit_span_a: assert property (tx_state_q == TX_START && !one_x && tx_bit_end |-> tx_sub_q == SUB_LAST)
    else $error("16x bit not sixteen ticks");
endmodule : urc_top

// [sim/urc_far_end.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Remote serial party: sends on rxd_pin, decodes txd
// ----------------------------------------
module urc_far_end (
  input  wire logic        pclk,
  input  wire logic        txd,
  input  wire logic [15:0] bit_cycles,
  output logic             rxd_pin,
  output logic [7:0]       got_byte,
  output int               got_n
);
  initial begin
    rxd_pin = 1'b1;
    got_byte = 8'h00;
    got_n = 0;
  end

  // Start, eight data bits LSB first, stop; line rests high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd_pin <= f[i];
      repeat (bit_cycles - 16'h1) @(posedge pclk);
    end
  endtask : send_byte

  // Mid-bit sampling; a start bit that vanishes is not a frame
  always begin
    @(negedge txd);
    repeat (bit_cycles / 2) @(posedge pclk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cycles) @(posedge pclk);
        got_byte[i] = txd;
      end
      repeat (bit_cycles) @(posedge pclk);
      if (txd === 1'b1) got_n = got_n + 1;
    end
  end
endmodule : urc_far_end

// [sim/uart_rate_select_and_channel_control_bench.sv]
`timescale 1ns/1ps
module uart_rate_select_and_channel_control_bench;
  import urc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, external_clock_pin, timer_tick;
  logic          pready, pslverr, irq, txd, rxd_pin, last_err;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [15:0]   far_bit;
  logic [7:0]    got_byte, test_port;
  int            got_n, fails, tests_run, tk;

  urc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .txd(txd), .rxd_pin(rxd_pin), .external_clock_pin(external_clock_pin), .timer_tick(timer_tick),
    .test_port(test_port));
  urc_far_end far_u (.pclk(pclk), .txd(txd), .bit_cycles(far_bit), .rxd_pin(rxd_pin),
    .got_byte(got_byte), .got_n(got_n));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Timer pulse every 4 cycles; external clock period 16 cycles
  always @(posedge pclk) begin
    tk <= tk + 1;
    timer_tick <= (tk % 4 == 3);
    if (tk % 8 == 7) external_clock_pin <= ~external_clock_pin;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run;
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [3:0] ix, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("unexpected at %0t: bus answer timeout", $time);
      complete_run();
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_txd(input logic v);
    int n;
    n = 0;
    while (txd !== v && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) begin
      fails++;
      $display("unexpected at %0t: line level timeout", $time);
      complete_run();
    end
  endtask : wait_txd

  // Bound covers the slowest character sent here
  task automatic wait_got(input int n0);
    int n;
    n = 0;
    while (got_n == n0 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40000) begin
      fails++;
      $display("unexpected at %0t: character timeout", $time);
      complete_run();
    end
  endtask : wait_got

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[6:2]), 32'h3, "reset status");
    apb(1'b0, 4'h9, 32'h0);
    chk(32'(last_err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
  endtask : t_reset

  task automatic t_rate;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, IX_RATE, 32'h0);
      chk(32'(rd[0]), 32'(i % 2), "rate mode before read");
      apb(1'b0, IX_STAT, 32'h0);
      chk(32'(rd[4]), 32'((i + 1) % 2), "shared rate mode");
    end
  endtask : t_rate

  task automatic t_tx;
    int n0;
    n0 = got_n;
    apb(1'b1, IX_CSEL, 32'hd0);
    apb(1'b1, IX_IMASK, 32'h1);
    apb(1'b1, IX_CMD, 32'h1);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[3]), 32'h1, "empty after enable");
    apb(1'b1, IX_DATA, 32'ha5);
    wait_txd(1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[2]), 32'h0, "ready inside start bit");
    repeat (60) @(posedge pclk);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[2]), 32'h1, "ready after start bit");
    chk(32'(irq), 32'h1, "irq on holding emptied");
    wait_got(n0);
    chk(32'(got_byte), 32'ha5, "sent byte");
    // Far end counts at mid stop bit; let the stop bit finish
    repeat (40) @(posedge pclk);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[3]), 32'h1, "empty on underrun");
    apb(1'b1, IX_ISTAT, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq cleared");
  endtask : t_tx

  task automatic t_abort;
    int n0;
    n0 = got_n;
    apb(1'b1, IX_DATA, 32'h5a);
    apb(1'b1, IX_CMD, 32'h2);
    repeat (1500) @(posedge pclk);
    chk(32'(got_n), 32'(n0), "early disable sends nothing");
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[2]), 32'h1, "discarded holding");
    apb(1'b1, IX_CMD, 32'h1);
    apb(1'b1, IX_DATA, 32'h3c);
    wait_txd(1'b0);
    repeat (80) @(posedge pclk);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[2]), 32'h1, "ready before disable");
    apb(1'b1, IX_CMD, 32'h2);
    wait_got(n0);
    chk(32'(got_byte), 32'h3c, "late disable completes");
  endtask : t_abort

  task automatic t_rx;
    apb(1'b1, IX_MODE, 32'h07);
    apb(1'b1, IX_CMD, 32'h4);
    far_u.send_byte(8'hc3);
    repeat (100) @(posedge pclk);
    apb(1'b0, IX_DATA, 32'h0);
    chk(32'(rd[7:0]), 32'hc3, "received byte");
    apb(1'b1, IX_CMD, 32'h10);
    apb(1'b1, IX_CMD, 32'h4);
    apb(1'b0, IX_MODE, 32'h0);
    chk(rd, 32'h07, "mode kept over reset");
    apb(1'b0, IX_CSEL, 32'h0);
    chk(rd, 32'hd0, "select kept over reset");
    apb(1'b1, IX_MODE, 32'h1f);
    apb(1'b1, IX_CMD, 32'h8);
    apb(1'b1, IX_CMD, 32'h10);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[1]), 32'h1, "wake-up ignores disable and reset");
    apb(1'b1, IX_MODE, 32'h07);
    apb(1'b1, IX_CMD, 32'h10);
    apb(1'b1, IX_MODE, 32'h1f);
    apb(1'b0, IX_STAT, 32'h0);
    chk(32'(rd[1]), 32'h0, "reset outside wake-up");
    apb(1'b0, IX_MODE, 32'h0);
    chk(rd, 32'h1f, "wake-up mode back");
  endtask : t_rx

  // External 16x and 1x sources; bit length follows the code
  task automatic t_codes;
    logic [3:0] cs [2] = '{CS_EXT16, CS_EXT1};
    logic [15:0] bt [2] = '{16'd256, 16'd16};
    int n0;
    for (int i = 0; i < 2; i++) begin
      far_bit = bt[i];
      n0 = got_n;
      apb(1'b1, IX_CSEL, {24'h0, cs[i], 4'h0});
      apb(1'b1, IX_CMD, 32'h1);
      apb(1'b1, IX_DATA, 32'h69 + 32'(i));
      wait_got(n0);
      chk(32'(got_byte), 32'h69 + 32'(i), "external clock byte");
    end
  endtask : t_codes

  // Timer code would be 16x; test mode makes a bit one tick long
  task automatic t_test;
    int n0;
    n0 = got_n;
    far_bit = 16'd4;
    apb(1'b1, IX_CSEL, 32'hd0);
    apb(1'b1, IX_TEST, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(test_port[1:0]), 32'h3, "test port shows 1x and line");
    apb(1'b1, IX_DATA, 32'h96);
    wait_got(n0);
    chk(32'(got_byte), 32'h96, "1x byte in test mode");
    apb(1'b1, IX_TEST, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(test_port), 32'h0, "test port quiet");
  endtask : t_test

  // Extended table, code 0110: start bit 15 to 16 ticks of about 108 cycles
  task automatic t_ext;
    int n, n0;
    n0 = got_n;
    far_bit = 16'd1736;
    apb(1'b1, IX_CSEL, 32'h60);
    apb(1'b0, IX_RATE, 32'h0);
    apb(1'b1, IX_DATA, 32'hff);
    wait_txd(1'b0);
    n = 0;
    while (txd === 1'b0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n > 1600 && n < 1760), 32'h1, "extended start bit length");
    wait_got(n0);
    chk(32'(got_byte), 32'hff, "extended rate byte");
  endtask : t_ext

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    presetn = 1'b0;
    timer_tick = 1'b0;
    external_clock_pin = 1'b0;
    tk = 0;
    fails = 0;
    tests_run = 0;
    far_bit = 16'd64;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rate();
    t_tx();
    t_abort();
    t_rx();
    t_codes();
    t_test();
    t_ext();
    complete_run();
  end
endmodule : uart_rate_select_and_channel_control_bench
